// ### logic/lcs_ctrl.sv
`timescale 1ns/1ps
module lcs_ctrl #(
  parameter int TEXT_DEPTH = lcs_pkg::TEXT_DEPTH
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  // host bus
  input wire logic BUS_STROBE,
  input wire logic REG_SELECT,
  input wire logic READ_NOT_WRITE,
  input wire logic [7:0] BUS_DIN,
  output logic [7:0] BUS_DOUT,
  output logic BUS_DOE,
  // configuration
  input wire logic EXT_SET,
  input wire logic STEP_DIR_LOAD,
  input wire logic STEP_DIR_IN,
  // status
  output logic BUSY,
  output logic [6:0] ADDR_PTR,
  output logic GLYPH_SEL,
  output logic STEP_DIR,
  output logic HOME_PULSE
);
  localparam int PW = lcs_pkg::PTR_W;

  if (TEXT_DEPTH < 1 || TEXT_DEPTH > (1 << PW) || TEXT_DEPTH > lcs_pkg::CYC_BLANK)
  begin : g_chk
    $error("lcs_ctrl: text depth out of range");
  end

  lcs_pkg::lcs_state_t state_q;
  logic strobe_q;
  logic [lcs_pkg::CNT_W-1:0] cnt_q;
  logic [PW-1:0] ptr_q;
  logic glyph_q;
  logic dir_q;
  logic reload_q;
  logic [7:0] data_q;
  logic [7:0] dout_q;
  logic home_q;
  logic [PW-1:0] fill_idx_q;
  logic busy;
  logic fall;
  logic accept;
  logic is_poll, is_rd, is_wr, is_cmd, is_blank, is_gset, is_tset;
  logic [PW-1:0] ptr_step;
  logic [7:0] text_rd;
  logic [lcs_pkg::GLYPH_W-1:0] glyph_rd;
  logic text_we;
  logic [PW-1:0] text_wa;
  logic [7:0] text_wd;
  logic glyph_we;
  logic fill_on;

  assign busy = cnt_q != lcs_pkg::CNT_ZERO;
  assign fall = strobe_q && !BUS_STROBE;
  // a strobe that ends while busy is dropped outright
  assign accept = CLK_EN && fall && !busy;
  assign is_poll = !REG_SELECT && READ_NOT_WRITE;
  assign is_rd = REG_SELECT && READ_NOT_WRITE;
  assign is_wr = REG_SELECT && !READ_NOT_WRITE;
  assign is_cmd = !REG_SELECT && !READ_NOT_WRITE;
  // 0x80 and 0x40 families mean other things in the extended set
  assign is_blank = is_cmd && !EXT_SET && BUS_DIN == lcs_pkg::CMD_BLANK;
  assign is_gset = is_cmd && !EXT_SET && !BUS_DIN[lcs_pkg::TEXT_SET_POS]
                   && BUS_DIN[7:6] == lcs_pkg::GLYPH_SET_TAG;
  assign is_tset = is_cmd && !EXT_SET && BUS_DIN[lcs_pkg::TEXT_SET_POS];
  assign ptr_step = dir_q ? ptr_q + lcs_pkg::PTR_ONE : ptr_q - lcs_pkg::PTR_ONE;
  assign fill_on = state_q == lcs_pkg::ST_FILL;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      strobe_q <= 1'b0;
    else if (CLK_EN)
      strobe_q <= BUS_STROBE;
  end

  // busy countdown; poll costs nothing and never loads it
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      cnt_q <= lcs_pkg::CNT_ZERO;
    else if (CLK_EN)
    begin
      if (accept && is_blank)
        cnt_q <= lcs_pkg::CNT_BLANK;
      else if (accept && !is_poll)
        cnt_q <= lcs_pkg::CNT_RW;
      else if (busy)
        cnt_q <= cnt_q - lcs_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_q <= lcs_pkg::ST_IDLE;
      fill_idx_q <= lcs_pkg::PTR_RST;
    end
    else if (CLK_EN)
    begin
      unique case (state_q)
        lcs_pkg::ST_IDLE:
        begin
          if (accept && is_blank)
          begin
            state_q <= lcs_pkg::ST_FILL;
            fill_idx_q <= lcs_pkg::PTR_RST;
          end
          else if (accept && !is_poll)
            state_q <= lcs_pkg::ST_RUN;
        end
        lcs_pkg::ST_RUN:
        begin
          if (cnt_q == lcs_pkg::CNT_ONE)
            state_q <= lcs_pkg::ST_IDLE;
        end
        lcs_pkg::ST_FILL:
        begin
          // the fill ends well before the busy window closes
          if (fill_idx_q == PW'(TEXT_DEPTH - 1))
            state_q <= lcs_pkg::ST_RUN;
          fill_idx_q <= fill_idx_q + lcs_pkg::PTR_ONE;
        end
        default:
          state_q <= lcs_pkg::ST_IDLE;
      endcase
    end
  end

  // shared pointer, RAM select and step direction
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ptr_q <= lcs_pkg::PTR_RST;
      glyph_q <= 1'b0;
    end
    else if (CLK_EN && accept)
    begin
      if (is_blank)
      begin
        ptr_q <= lcs_pkg::PTR_RST;
        glyph_q <= 1'b0;
      end
      else if (is_gset)
      begin
        ptr_q <= {1'b0, BUS_DIN[lcs_pkg::GLYPH_AW-1:0]};
        glyph_q <= 1'b1;
      end
      else if (is_tset)
      begin
        ptr_q <= BUS_DIN[PW-1:0];
        glyph_q <= 1'b0;
      end
      else if (is_rd || is_wr)
        ptr_q <= ptr_step;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      dir_q <= 1'b1;
    else if (CLK_EN)
    begin
      if (accept && is_blank)
        dir_q <= 1'b1;
      else if (STEP_DIR_LOAD)
        dir_q <= STEP_DIR_IN;
    end
  end

  // data register: reloaded the cycle after the pointer settles
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      reload_q <= 1'b0;
      data_q <= lcs_pkg::DATA_RST;
    end
    else if (CLK_EN)
    begin
      reload_q <= accept && (is_rd || is_gset || is_tset);
      if (reload_q)
        data_q <= glyph_q ? {3'h0, glyph_rd} : text_rd;
    end
  end

  // registered bus data; the register goes out while a read strobe is high
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      dout_q <= lcs_pkg::DATA_RST;
    else if (CLK_EN)
      dout_q <= REG_SELECT ? data_q : {busy, ptr_q};
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      home_q <= 1'b0;
    else if (CLK_EN)
      home_q <= accept && is_blank;
  end

  // the fill owns the text write port; no data write can be accepted meanwhile
  assign text_we = fill_on || (accept && is_wr && !glyph_q);
  assign text_wa = fill_on ? fill_idx_q : ptr_q;
  assign text_wd = fill_on ? lcs_pkg::BLANK_CHAR : BUS_DIN;
  assign glyph_we = accept && is_wr && glyph_q;

  lcs_ram #(.W(8), .DEPTH(TEXT_DEPTH), .AW(PW)) u_text_ram (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CLK_EN),
    .we(text_we),
    .waddr(text_wa),
    .wdata(text_wd),
    .raddr(ptr_q),
    .rdata(text_rd)
  );

  lcs_ram #(.W(lcs_pkg::GLYPH_W), .DEPTH(lcs_pkg::GLYPH_DEPTH), .AW(lcs_pkg::GLYPH_AW))
    u_glyph_ram (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CLK_EN),
    .we(glyph_we),
    .waddr(ptr_q[lcs_pkg::GLYPH_AW-1:0]),
    .wdata(BUS_DIN[lcs_pkg::GLYPH_W-1:0]),
    .raddr(ptr_q[lcs_pkg::GLYPH_AW-1:0]),
    .rdata(glyph_rd)
  );

  assign BUS_DOUT = dout_q;
  assign BUS_DOE = BUS_STROBE && READ_NOT_WRITE;
  assign BUSY = busy;
  assign ADDR_PTR = ptr_q;
  assign GLYPH_SEL = glyph_q;
  assign STEP_DIR = dir_q;
  assign HOME_PULSE = home_q;

  property p_poll_out;
    @(posedge SYS_CLK) disable iff (RST || !CLK_EN)
    (!REG_SELECT && READ_NOT_WRITE) |=> BUS_DOUT == {$past(busy), $past(ptr_q)};
  endproperty
  a_poll_out: assert property (p_poll_out) else $error("status byte wrong");

  property p_busy_drop;
    @(posedge SYS_CLK) disable iff (RST || !CLK_EN)
    (fall && busy) |=> ptr_q == $past(ptr_q) && !home_q;
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("command taken while busy");

  property p_step;
    @(posedge SYS_CLK) disable iff (RST || !CLK_EN)
    (accept && (is_rd || is_wr)) |=>
      ptr_q == ($past(dir_q) ? $past(ptr_q) + 7'h01 : $past(ptr_q) - 7'h01);
  endproperty
  a_step: assert property (p_step) else $error("pointer step wrong");

  property p_read_reload;
    @(posedge SYS_CLK) disable iff (RST || !CLK_EN)
    (accept && is_rd) |=> ##1 data_q == (glyph_q ? {3'h0, $past(glyph_rd)} : $past(text_rd));
  endproperty
  a_read_reload: assert property (p_read_reload) else $error("read reload wrong");

  property p_write_keeps;
    @(posedge SYS_CLK) disable iff (RST || !CLK_EN)
    (accept && is_wr) |=> ##1 $stable(data_q);
  endproperty
  a_write_keeps: assert property (p_write_keeps) else $error("write touched data");

  property p_blank_state;
    @(posedge SYS_CLK) disable iff (RST || !CLK_EN)
    (accept && is_blank) |=> ptr_q == 7'h00 && !glyph_q && dir_q && home_q ##1 !home_q;
  endproperty
  a_blank_state: assert property (p_blank_state) else $error("blank state wrong");

  property p_blank_busy;
    @(posedge SYS_CLK) disable iff (RST || !CLK_EN)
    (accept && is_blank) |=> busy ##164 busy ##1 !busy;
  endproperty
  a_blank_busy: assert property (p_blank_busy) else $error("blank busy length wrong");

  property p_fill_len;
    @(posedge SYS_CLK) disable iff (RST || !CLK_EN)
    (accept && is_blank) |=> fill_on && text_wd == 8'h20 ##79 fill_on ##1 !fill_on;
  endproperty
  a_fill_len: assert property (p_fill_len) else $error("fill length wrong");

  property p_access_time;
    @(posedge SYS_CLK) disable iff (RST || !CLK_EN)
    (accept && (is_rd || is_wr)) |=> busy[*3] ##1 !busy;
  endproperty
  a_access_time: assert property (p_access_time) else $error("access time wrong");

  property p_ext_no_blank;
    @(posedge SYS_CLK) disable iff (RST || !CLK_EN)
    (accept && is_cmd && EXT_SET) |=> !fill_on && !home_q;
  endproperty
  a_ext_no_blank: assert property (p_ext_no_blank) else $error("blank in extended set");

  property p_wrap;
    @(posedge SYS_CLK) disable iff (RST || !CLK_EN)
    (accept && is_wr && dir_q && ptr_q == 7'h7F) |=> ptr_q == 7'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");
endmodule

// ### logic/lcs_pkg.sv
package lcs_pkg;
  localparam int DATA_W = 8;
  localparam int PTR_W = 7;
  localparam int TEXT_DEPTH = 80;
  localparam int GLYPH_DEPTH = 64;
  localparam int GLYPH_AW = 6;
  localparam int GLYPH_W = 5;
  localparam int BUSY_POS = 7;
  // execution times in oscillator (SYS_CLK) cycles
  localparam int CYC_POLL = 0;
  localparam int CYC_RW = 3;
  localparam int CYC_BLANK = 165;
  localparam int CNT_W = $clog2(CYC_BLANK + 1);
  localparam logic [CNT_W-1:0] CNT_RW = CNT_W'(CYC_RW);
  localparam logic [CNT_W-1:0] CNT_BLANK = CNT_W'(CYC_BLANK);
  localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  // command codes
  localparam logic [7:0] CMD_BLANK = 8'h01;
  localparam logic [1:0] GLYPH_SET_TAG = 2'h1;
  localparam int TEXT_SET_POS = 7;
  localparam logic [7:0] BLANK_CHAR = 8'h20;
  localparam logic [PTR_W-1:0] PTR_RST = 7'h00;
  localparam logic [PTR_W-1:0] PTR_ONE = 7'h01;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [PTR_W-1:0] FILL_LAST = PTR_W'(TEXT_DEPTH - 1);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_FILL = 3'b100
  } lcs_state_t;
endpackage

// ### logic/lcs_ram.sv
`timescale 1ns/1ps
module lcs_ram #(
  parameter int W = 8,
  parameter int DEPTH = 80,
  parameter int AW = 7
) (
  // clock
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem_q [DEPTH];

  if (DEPTH > (1 << AW) || DEPTH < 1 || W < 1)
  begin : g_chk
    $error("lcs_ram: depth does not fit the address width");
  end

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_ent
    always_ff @(posedge clk)
    begin
      if (rst)
        mem_q[i] <= '0;
      else if (ce && we && waddr == AW'(i))
        mem_q[i] <= wdata;
    end
  end

  // addresses past the last entry read as zero and swallow writes
  always_comb
  begin
    rdata = '0;
    if (32'(raddr) < DEPTH)
      rdata = mem_q[raddr];
  end
endmodule

// ### test/lcs_host.sv
`timescale 1ns/1ps
module lcs_host (
  // clock
  input wire logic clk,
  // bus towards the controller
  output logic strobe,
  output logic sel,
  output logic rw,
  output logic [7:0] din,
  input wire logic [7:0] dout
);
  int n_timeouts = 0;

  initial
  begin
    strobe = 1'b0;
    sel = 1'b0;
    rw = 1'b1;
    din = 8'h00;
  end

  // one byte per strobe; levels held through the fall cycle
  task automatic cycle(input logic r_s, input logic r_w, input logic [7:0] d,
                       output logic [7:0] q);
    @(negedge clk);
    sel = r_s;
    rw = r_w;
    din = d;
    strobe = 1'b1;
    repeat (2) @(negedge clk);
    q = dout;
    strobe = 1'b0;
    @(negedge clk);
    // released lines must not keep the last byte
    din = ~d;
  endtask

  task automatic wait_ready();
    logic [7:0] q;
    int n;
    n = 0;
    q = 8'h80;
    while (q[7] !== 1'b0 && n < 400)
    begin
      cycle(1'b0, 1'b1, 8'h00, q);
      n++;
    end
    // a controller that never drops busy is reported, not waited on forever
    if (q[7] !== 1'b0)
      n_timeouts++;
  endtask

  task automatic issue(input logic r_s, input logic r_w, input logic [7:0] d,
                       output logic [7:0] q);
    cycle(r_s, r_w, d, q);
    wait_ready();
  endtask

  // in 4-bit operation the first configuration is forced, so it always goes twice
  task automatic configure(input logic [7:0] fs);
    logic [7:0] q;
    repeat (2) issue(1'b0, 1'b0, fs, q);
  endtask

  // charsets whose code 20h is not blank: display off, fill by hand, display on
  task automatic blank_manual(input logic [7:0] pat);
    logic [7:0] q;
    issue(1'b0, 1'b0, 8'h08, q);
    issue(1'b0, 1'b0, 8'h80, q);
    repeat (80) issue(1'b1, 1'b0, pat, q);
    issue(1'b0, 1'b0, 8'h0C, q);
  endtask
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic CLK_EN = 1'b1;
  logic EXT_SET = 1'b0;
  logic STEP_DIR_LOAD = 1'b0;
  logic STEP_DIR_IN = 1'b1;
  logic BUS_STROBE, REG_SELECT, READ_NOT_WRITE, BUS_DOE;
  logic BUSY, GLYPH_SEL, STEP_DIR, HOME_PULSE;
  logic [7:0] BUS_DIN, BUS_DOUT, q;
  logic [6:0] ADDR_PTR;
  int n_home = 0;
  int home_base = 0;
  int doe_bad = 0;
  int num_errors = 0;
  int n_compared = 0;
  int run = 0;
  int last_run = 0;

  always #2.5 SYS_CLK = ~SYS_CLK;

  lcs_ctrl dut_u (.SYS_CLK(SYS_CLK), .RST(RST), .CLK_EN(CLK_EN), .BUS_STROBE(BUS_STROBE),
    .REG_SELECT(REG_SELECT), .READ_NOT_WRITE(READ_NOT_WRITE), .BUS_DIN(BUS_DIN),
    .BUS_DOUT(BUS_DOUT), .BUS_DOE(BUS_DOE), .EXT_SET(EXT_SET), .STEP_DIR_LOAD(STEP_DIR_LOAD),
    .STEP_DIR_IN(STEP_DIR_IN), .BUSY(BUSY), .ADDR_PTR(ADDR_PTR), .GLYPH_SEL(GLYPH_SEL),
    .STEP_DIR(STEP_DIR), .HOME_PULSE(HOME_PULSE));
  lcs_host host_u (.clk(SYS_CLK), .strobe(BUS_STROBE), .sel(REG_SELECT),
    .rw(READ_NOT_WRITE), .din(BUS_DIN), .dout(BUS_DOUT));

  // length of the last busy stretch, latched as busy drops
  always @(posedge SYS_CLK)
  begin
    if (BUSY === 1'b1)
      run <= run + 1;
    else if (run != 0)
    begin
      last_run <= run;
      run <= 0;
    end
    if (HOME_PULSE === 1'b1)
      n_home <= n_home + 1;
    // the bus is driven only while a read strobe stands
    if (BUS_DOE !== (BUS_STROBE === 1'b1 && READ_NOT_WRITE === 1'b1))
      doe_bad <= doe_bad + 1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] d);
    host_u.issue(1'b0, 1'b0, d, q);
  endtask

  task automatic wr(input logic [7:0] d);
    host_u.issue(1'b1, 1'b0, d, q);
  endtask

  task automatic rd(input logic [7:0] exp);
    host_u.issue(1'b1, 1'b1, 8'h00, q);
    check(q, exp);
  endtask

  task automatic ptr(input logic [6:0] exp);
    host_u.cycle(1'b0, 1'b1, 8'h00, q);
    check(q, {1'b0, exp});
    check({1'b0, ADDR_PTR}, {1'b0, exp});
  endtask

  task automatic flags(input logic g, input logic s);
    check({6'h00, GLYPH_SEL, STEP_DIR}, {6'h00, g, s});
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    num_errors++;
    close_out();
  end

  initial
  begin
    repeat (20) @(negedge SYS_CLK);
    RST = 1'b0;
    ptr(7'h00);
    flags(1'b0, 1'b1);
    check({7'h00, BUSY}, 8'h00);
    host_u.configure(8'h34);
    ptr(7'h00);
    $display("test reset done");
    cmd(8'h85);
    check(8'(last_run), 8'h03);
    ptr(7'h05);
    wr(8'hA1);
    wr(8'hB2);
    ptr(7'h07);
    check(8'(last_run), 8'h03);
    cmd(8'h85);
    rd(8'hA1);
    rd(8'hB2);
    wr(8'hC3);
    rd(8'h00);
    ptr(7'h09);
    cmd(8'h87);
    rd(8'hC3);
    $display("test text done");
    cmd(8'h43);
    flags(1'b1, 1'b1);
    ptr(7'h03);
    wr(8'hFF);
    cmd(8'h43);
    rd(8'h1F);
    $display("test glyph done");
    @(negedge SYS_CLK);
    STEP_DIR_IN = 1'b0;
    STEP_DIR_LOAD = 1'b1;
    @(negedge SYS_CLK);
    STEP_DIR_LOAD = 1'b0;
    cmd(8'h80);
    wr(8'h11);
    ptr(7'h7F);
    flags(1'b0, 1'b0);
    EXT_SET = 1'b1;
    cmd(8'h01);
    ptr(7'h7F);
    flags(1'b0, 1'b0);
    check(8'(last_run), 8'h03);
    EXT_SET = 1'b0;
    $display("test decrement done");
    cmd(8'h85);
    home_base = n_home;
    host_u.cycle(1'b0, 1'b0, 8'h01, q);
    // this write lands while blanking runs and must vanish
    host_u.cycle(1'b1, 1'b0, 8'h55, q);
    host_u.wait_ready();
    check(8'(last_run), 8'hA5);
    ptr(7'h00);
    flags(1'b0, 1'b1);
    check(8'(n_home - home_base), 8'h01);
    rd(8'hA1);
    rd(8'h20);
    cmd(8'h80);
    rd(8'h20);
    cmd(8'hCF);
    rd(8'h20);
    $display("test blank done");
    // pointer is 50h here: the write is swallowed past text RAM but still steps
    host_u.cycle(1'b1, 1'b0, 8'h44, q);
    CLK_EN = 1'b0;
    repeat (4) @(negedge SYS_CLK);
    CLK_EN = 1'b1;
    host_u.wait_ready();
    // three busy cycles plus four frozen ones
    check(8'(last_run), 8'h07);
    ptr(7'h51);
    CLK_EN = 1'b0;
    // a strobe while frozen never reaches the edge detector
    host_u.cycle(1'b1, 1'b0, 8'h66, q);
    CLK_EN = 1'b1;
    ptr(7'h51);
    $display("test freeze done");
    cmd(8'hFF);
    wr(8'h33);
    ptr(7'h00);
    host_u.blank_manual(8'h5A);
    ptr(7'h50);
    cmd(8'hCF);
    rd(8'h5A);
    cmd(8'h80);
    rd(8'h5A);
    $display("test manual blank done");
    @(negedge SYS_CLK);
    RST = 1'b1;
    repeat (2) @(negedge SYS_CLK);
    RST = 1'b0;
    ptr(7'h00);
    flags(1'b0, 1'b1);
    cmd(8'h81);
    rd(8'h00);
    check(8'(doe_bad), 8'h00);
    check(8'(host_u.n_timeouts), 8'h00);
    $display("test reset again done");
    close_out();
  end
endmodule
